// *** shared/isp_consts.svh ***
// constants of the serial programming link: encodings, counts, erase values
// assumes the clock of both ends is core_clk at the rate given here
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH
`define ISP_CLK_NS          10.0
`define ISP_T_PWRUP_MS      20.0
`define ISP_T_WD_FLASH_MS   4.5
`define ISP_T_WD_EEPROM_MS  4.0
`define ISP_T_WD_ERASE_MS   4.0
`define ISP_SCK_PH_LAST     4'h7
`define ISP_RST_PULSE       22'h000004
`define ISP_PE_B1           8'hAC
`define ISP_PE_B2           8'h53
`define ISP_PE_WORD         32'hAC53_0000
`define ISP_POLL_WORD       32'hF000_0000
`define ISP_ERASE_B2        3'h4
`define ISP_RD_FLASH_HI     4'h2
`define ISP_LD_FLASH_HI     4'h4
`define ISP_WR_FLASH        8'h4C
`define ISP_RD_EE           8'hA0
`define ISP_WR_EE           8'hC0
`define ISP_LD_EE           8'hC1
`define ISP_WR_EE_PAGE      8'hC2
`define ISP_POLL            8'hF0
`define ISP_ERASE_WORD      16'hFFFF
`define ISP_ERASE_BYTE      8'hFF
`define ISP_FLASH_LAST      10'h3FF
`define ISP_FPAGE_LAST      6'h3F
`define ISP_EPAGE_LAST      2'h3
`define ISP_BYTE_LAST       3'h7
`define ISP_WORD_LAST       5'h1F
`define ISP_BYTE3_LAST      5'h17
`endif

// *** shared/isp_pkg.sv ***
// types shared by both ends of the serial programming link
// assumes isp_consts.svh for the numbers
package isp_pkg;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_FCOPY, OP_ECOPY} dev_op_e;
    typedef enum logic [2:0] {HS_OFF, HS_WAIT, HS_PULSE, HS_IDLE, HS_SHIFT} host_st_e;
    typedef enum logic [1:0] {XK_ENABLE, XK_USER, XK_POLL} xfer_kind_e;

    typedef struct packed {
        logic        sck_m;
        logic        sck_s;
        logic        sck_p;
        logic        mosi_m;
        logic        mosi_s;
        logic        rst_m;
        logic        rst_s;
        logic [4:0]  bitcnt;
        logic [31:0] shin;
        logic [7:0]  outb;
        logic        miso;
        logic        enabled;
        dev_op_e     op;
        logic [9:0]  ptr;
        logic [7:0]  page;
        logic [21:0] busy_cnt;
        logic [63:0] fvalid;
        logic [3:0]  evalid;
        logic [15:0] fetch_data;
    } dev_state_s;

    typedef struct packed {
        host_st_e    st;
        xfer_kind_e  kind;
        logic        sck;
        logic        mosi;
        logic        rst_pin_n;
        logic        miso_m;
        logic        miso_s;
        logic [3:0]  ph;
        logic [4:0]  bitcnt;
        logic [31:0] sh;
        logic [31:0] rx;
        logic [21:0] cnt;
        logic        synced;
        logic        poll_pend;
        logic [31:0] rsp_data;
        logic        rsp_valid;
        logic [7:0]  op_code;
    } host_state_s;
endpackage : isp_pkg

// *** shared/isp_link_if.sv ***
// the four wires between programmer and target
// assumes both ends run from their own core_clk; no wire is two-way
`timescale 1ns/1ps
interface isp_link_if;
    logic sck;
    logic mosi;
    logic miso;
    logic rst_pin_n;
    modport device (input sck, input mosi, input rst_pin_n, output miso);
    modport host (output sck, output mosi, output rst_pin_n, input miso);
endinterface : isp_link_if

// *** src/isp_fifo.sv ***
// instruction queue between the user port and the programmer's shifter
// assumes one clock; out_data is read straight from the storage flops
`timescale 1ns/1ps
module isp_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_state_s;

    fifo_state_s  s_r;
    fifo_state_s  s_nxt;
    logic [W-1:0] mem [0:D-1];

    // extra pointer bit tells full from empty
    assign in_ready  = (s_r.wp[AW] == s_r.rp[AW]) || (s_r.wp[AW-1:0] != s_r.rp[AW-1:0]);
    assign out_valid = (s_r.wp != s_r.rp);
    assign out_data  = mem[s_r.rp[AW-1:0]];

    // pointer update on accepted pushes and pops
    always_comb begin
        s_nxt = s_r;
        if (in_valid && in_ready) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (out_valid && out_ready) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // storage has no reset; empty slots are never read out
    always_ff @(posedge core_clk) begin
        if (in_valid && in_ready) begin
            mem[s_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule : isp_fifo

// *** src/isp_programmer.sv ***
// programmer end: makes sck, drives the target reset pin, syncs, queues
// assumes the target end on the far side of isp_link_if.host
`timescale 1ns/1ps
`include "isp_consts.svh"
module isp_programmer #(
    parameter int unsigned PWRUP_CYC = $rtoi($ceil(`ISP_T_PWRUP_MS * 1.0E6 / `ISP_CLK_NS))
) (
    input  wire logic   core_clk,
    input  wire logic   reset,
    isp_link_if.host    link,
    input  wire logic   session_en,
    input  wire logic [31:0] cmd_data,
    input  wire logic   cmd_valid,
    output logic        cmd_ready,
    output logic [31:0] rsp_data,
    output logic        rsp_valid,
    output logic        synced
);
    isp_pkg::host_state_s s_r;
    isp_pkg::host_state_s s_nxt;
    logic [31:0]          q_data;
    logic                 q_valid;
    logic                 q_pop;
    logic [31:0]          rx_w;
    logic [7:0]           b1;

    // queued words leave in the order the user gave them
    isp_fifo #(.W(32), .D(8)) u_queue (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_data   (cmd_data),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (q_pop)
    );

    // pop only when synced, idle and no write is still being polled
    assign q_pop = (s_r.st == isp_pkg::HS_IDLE) && s_r.synced && !s_r.poll_pend && session_en;

    assign link.sck       = s_r.sck;
    assign link.mosi      = s_r.mosi;
    assign link.rst_pin_n = s_r.rst_pin_n;
    assign rsp_data       = s_r.rsp_data;
    assign rsp_valid      = s_r.rsp_valid;
    assign synced         = s_r.synced;

    function automatic isp_pkg::host_state_s start(isp_pkg::host_state_s h, logic [31:0] w,
                                                   isp_pkg::xfer_kind_e k);
        isp_pkg::host_state_s r;
        r        = h;
        r.st     = isp_pkg::HS_SHIFT;
        r.kind   = k;
        r.sh      = w;
        r.op_code = w[31:24];
        r.mosi    = w[31];
        r.sck    = 1'b0;
        r.ph     = '0;
        r.bitcnt = '0;
        return r;
    endfunction : start

    // sequencing: power-up wait, enable with echo check, queue, busy poll
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp_valid = 1'b0;
        s_nxt.miso_m    = link.miso;
        s_nxt.miso_s    = s_r.miso_m;
        rx_w            = {s_r.rx[30:0], s_r.miso_s};
        b1              = s_r.op_code; // the shifter has moved past byte one by the last bit
        unique case (s_r.st)
            isp_pkg::HS_OFF: begin
                s_nxt.rst_pin_n = 1'b1;
                s_nxt.synced    = 1'b0;
                if (session_en) begin
                    s_nxt.rst_pin_n = 1'b0;
                    s_nxt.cnt       = 22'(PWRUP_CYC);
                    s_nxt.st        = isp_pkg::HS_WAIT;
                end
            end
            isp_pkg::HS_WAIT: begin
                s_nxt.cnt = s_r.cnt - 1'b1;
                if (s_r.cnt == '0) begin
                    if (session_en) begin
                        s_nxt = start(s_nxt, `ISP_PE_WORD, isp_pkg::XK_ENABLE);
                    end else begin
                        s_nxt.st = isp_pkg::HS_OFF;
                    end
                end
            end
            isp_pkg::HS_PULSE: begin
                s_nxt.cnt = s_r.cnt - 1'b1;
                if (s_r.cnt == '0) begin
                    s_nxt.rst_pin_n = 1'b0;
                    s_nxt = start(s_nxt, `ISP_PE_WORD, isp_pkg::XK_ENABLE);
                end
            end
            isp_pkg::HS_IDLE: begin
                if (!session_en) begin
                    s_nxt.st = isp_pkg::HS_OFF;
                end else if (s_r.poll_pend) begin
                    s_nxt = start(s_nxt, `ISP_POLL_WORD, isp_pkg::XK_POLL);
                end else if (q_valid) begin
                    s_nxt = start(s_nxt, q_data, isp_pkg::XK_USER);
                end
            end
            isp_pkg::HS_SHIFT: begin
                s_nxt.ph = s_r.ph + 1'b1;
                // each sck phase lasts eight clocks, above the three needed
                if (s_r.ph == `ISP_SCK_PH_LAST) begin
                    s_nxt.ph = '0;
                    if (!s_r.sck) begin
                        s_nxt.sck = 1'b1;
                    end else begin
                        s_nxt.sck    = 1'b0;
                        s_nxt.rx     = rx_w;
                        s_nxt.sh     = {s_r.sh[30:0], 1'b0};
                        s_nxt.mosi   = s_r.sh[30];
                        s_nxt.bitcnt = s_r.bitcnt + 1'b1;
                        if (s_r.bitcnt == `ISP_WORD_LAST) begin
                            s_nxt.st = isp_pkg::HS_IDLE;
                            unique case (s_r.kind)
                                isp_pkg::XK_ENABLE: begin
                                    if (rx_w[15:8] == `ISP_PE_B2) begin
                                        s_nxt.synced = 1'b1;
                                    end else begin
                                        s_nxt.rst_pin_n = 1'b1;
                                        s_nxt.cnt       = `ISP_RST_PULSE;
                                        s_nxt.st        = isp_pkg::HS_PULSE;
                                    end
                                end
                                isp_pkg::XK_USER: begin
                                    s_nxt.rsp_data  = rx_w;
                                    s_nxt.rsp_valid = 1'b1;
                                    s_nxt.poll_pend = (b1 == `ISP_WR_FLASH) || (b1 == `ISP_WR_EE)
                                                      || (b1 == `ISP_WR_EE_PAGE) || (b1 == `ISP_PE_B1);
                                end
                                default: begin
                                    s_nxt.poll_pend = rx_w[0];
                                end
                            endcase
                        end
                    end
                end
            end
            default: s_nxt.st = isp_pkg::HS_OFF;
        endcase
    end

    // reset holds the target in reset with sck low and starts the wait
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r     <= '0;
            s_r.st  <= isp_pkg::HS_WAIT;
            s_r.cnt <= 22'(PWRUP_CYC);
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule : isp_programmer

// *** src/isp_target.sv ***
// target end: serial programming engine with flash, eeprom and page buffers
// assumes the programmer on the far side of isp_link_if.device; link pins are asynchronous
`timescale 1ns/1ps
`include "isp_consts.svh"
// Function
// - programming only while reset pin low
// - enable instruction first, else nothing executes
// - eeprom write erases location itself
// - chip erase fills both arrays with FF
// - programmer keeps sck phases above three clocks
// - mosi sampled on sck rising edge
// - miso shifted on sck falling edge
// - programmer holds reset low, pulses if needed
// - programmer waits 20 ms before enabling
// - second enable byte echoed during third
// - programmer sends four bytes, retries bad echo
// - flash page buffer loaded by 6-bit offset
// - programmer loads low byte before high
// - flash page committed by 8-bit page
// - programmer waits or polls after page write
// - eeprom byte write carries address and data
// - eeprom page buffer loaded by 2-bit offset
// - eeprom page committed by 4-bit page
// - eeprom page write touches loaded bytes only
// - read instruction returns stored content on miso
// - reset pin high ends programming mode
// - enable is AC 53 then two bytes
// - poll returns busy bit in last byte
module isp_target #(
    parameter int unsigned FLASH_WAIT_CYC = $rtoi($ceil(`ISP_T_WD_FLASH_MS * 1.0E6 / `ISP_CLK_NS)),
    parameter int unsigned EE_WAIT_CYC    = $rtoi($ceil(`ISP_T_WD_EEPROM_MS * 1.0E6 / `ISP_CLK_NS)),
    parameter int unsigned ERASE_WAIT_CYC = $rtoi($ceil(`ISP_T_WD_ERASE_MS * 1.0E6 / `ISP_CLK_NS))
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    isp_link_if.device       link,
    input  wire logic [9:0]  fetch_addr,
    output logic [15:0]      fetch_data,
    output logic             prog_mode,
    output logic             write_in_progress_flag
);
    isp_pkg::dev_state_s s_r;
    isp_pkg::dev_state_s s_nxt;

    logic [15:0] flash_mem [0:1023];
    logic [7:0]  ee_mem    [0:127];
    logic [15:0] fbuf      [0:63];
    logic [7:0]  ebuf      [0:3];

    logic        fl_we;
    logic [9:0]  fl_addr;
    logic [15:0] fl_wd;
    logic        ee_we;
    logic [6:0]  ee_addr;
    logic [7:0]  ee_wd;
    logic        fb_we_lo;
    logic        fb_we_hi;
    logic [5:0]  fb_idx;
    logic        eb_we;
    logic [1:0]  eb_idx;
    logic [7:0]  buf_wd;
    logic        rise;
    logic        fall;
    logic        busy;
    logic [31:0] sh;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [7:0]  b4;
    logic [15:0] rd_word;

    assign link.miso              = s_r.miso;
    assign fetch_data             = s_r.fetch_data;
    assign prog_mode              = s_r.enabled;
    assign busy                   = (s_r.busy_cnt != '0) || (s_r.op != isp_pkg::OP_IDLE);
    assign write_in_progress_flag = busy;

    // link decode, background copy or erase, instruction execution
    always_comb begin
        s_nxt            = s_r;
        fl_we            = 1'b0;
        fl_addr          = s_r.ptr;
        fl_wd            = `ISP_ERASE_WORD;
        ee_we            = 1'b0;
        ee_addr          = s_r.ptr[6:0];
        ee_wd            = `ISP_ERASE_BYTE;
        fb_we_lo         = 1'b0;
        fb_we_hi         = 1'b0;
        eb_we            = 1'b0;
        s_nxt.sck_m      = link.sck;
        s_nxt.sck_s      = s_r.sck_m;
        s_nxt.sck_p      = s_r.sck_s;
        s_nxt.mosi_m     = link.mosi;
        s_nxt.mosi_s     = s_r.mosi_m;
        s_nxt.rst_m      = link.rst_pin_n;
        s_nxt.rst_s      = s_r.rst_m;
        s_nxt.fetch_data = flash_mem[fetch_addr];
        rise             = s_r.sck_s && !s_r.sck_p;
        fall             = !s_r.sck_s && s_r.sck_p;
        sh               = {s_r.shin[30:0], s_r.mosi_s};
        b1               = sh[31:24];
        b2               = sh[23:16];
        b3               = sh[15:8];
        b4               = sh[7:0];
        fb_idx           = b3[5:0];
        eb_idx           = b3[1:0];
        buf_wd           = b4;
        rd_word          = flash_mem[{b2[1:0], b3}];
        if (s_r.busy_cnt != '0) begin
            s_nxt.busy_cnt = s_r.busy_cnt - 1'b1;
        end
        // array work runs one location a clock, well inside the wait time
        unique case (s_r.op)
            isp_pkg::OP_IDLE: begin
            end
            isp_pkg::OP_ERASE: begin
                fl_we     = 1'b1;
                ee_we     = 1'b1;
                s_nxt.ptr = s_r.ptr + 1'b1;
                if (s_r.ptr == `ISP_FLASH_LAST) begin
                    s_nxt.op = isp_pkg::OP_IDLE;
                end
            end
            isp_pkg::OP_FCOPY: begin
                fl_we   = s_r.fvalid[s_r.ptr[5:0]];
                fl_addr = 10'({s_r.page, s_r.ptr[5:0]});
                fl_wd   = fbuf[s_r.ptr[5:0]];
                s_nxt.fvalid[s_r.ptr[5:0]] = 1'b0;
                s_nxt.ptr = s_r.ptr + 1'b1;
                if (s_r.ptr[5:0] == `ISP_FPAGE_LAST) begin
                    s_nxt.op = isp_pkg::OP_IDLE;
                end
            end
            isp_pkg::OP_ECOPY: begin
                ee_we   = s_r.evalid[s_r.ptr[1:0]];
                ee_addr = 7'({s_r.page[3:0], s_r.ptr[1:0]});
                ee_wd   = ebuf[s_r.ptr[1:0]];
                s_nxt.evalid[s_r.ptr[1:0]] = 1'b0;
                s_nxt.ptr = s_r.ptr + 1'b1;
                if (s_r.ptr[1:0] == `ISP_EPAGE_LAST) begin
                    s_nxt.op = isp_pkg::OP_IDLE;
                end
            end
        endcase
        if (s_r.rst_s) begin
            // pin high: normal operation, link ignored, enable forgotten
            s_nxt.enabled = 1'b0;
            s_nxt.bitcnt  = '0;
            s_nxt.outb    = '0;
            s_nxt.miso    = 1'b0;
        end else begin
            if (fall) begin
                s_nxt.miso = s_r.outb[7];
                s_nxt.outb = {s_r.outb[6:0], 1'b0};
            end
            if (rise) begin
                s_nxt.shin   = sh;
                s_nxt.bitcnt = s_r.bitcnt + 1'b1;
                if (s_r.bitcnt[2:0] == `ISP_BYTE_LAST) begin
                    // each byte taken is echoed in the next byte slot, unless a read or poll answer replaces the echo of byte three
                    s_nxt.outb = b4;
                    if (s_r.bitcnt == `ISP_BYTE3_LAST && s_r.enabled) begin
                        // here sh holds bytes one to three in its low bits
                        if (sh[23:20] == `ISP_RD_FLASH_HI && sh[18:16] == 3'h0) begin
                            rd_word    = flash_mem[{sh[9:8], sh[7:0]}];
                            s_nxt.outb = sh[19] ? rd_word[15:8] : rd_word[7:0];
                        end else if (sh[23:16] == `ISP_RD_EE) begin
                            s_nxt.outb = ee_mem[sh[6:0]];
                        end else if (sh[23:16] == `ISP_POLL) begin
                            s_nxt.outb = {7'h00, busy};
                        end
                    end
                    if (s_r.bitcnt == `ISP_WORD_LAST) begin
                        if (!s_r.enabled) begin
                            // nothing but a correct enable word is obeyed here
                            if (b1 == `ISP_PE_B1 && b2 == `ISP_PE_B2) begin
                                s_nxt.enabled = 1'b1;
                            end
                        end else if (!busy) begin
                            if (b1 == `ISP_PE_B1 && b2[7:5] == `ISP_ERASE_B2) begin
                                s_nxt.op       = isp_pkg::OP_ERASE;
                                s_nxt.ptr      = '0;
                                s_nxt.fvalid   = '0;
                                s_nxt.evalid   = '0;
                                s_nxt.busy_cnt = 22'(ERASE_WAIT_CYC);
                            end else if (b1[7:4] == `ISP_LD_FLASH_HI && b1[2:0] == 3'h0) begin
                                fb_we_lo = !b1[3];
                                fb_we_hi = b1[3];
                                s_nxt.fvalid[fb_idx] = 1'b1;
                            end else if (b1 == `ISP_WR_FLASH) begin
                                s_nxt.op       = isp_pkg::OP_FCOPY;
                                s_nxt.page     = {b2[1:0], b3[7:2]};
                                s_nxt.ptr      = '0;
                                s_nxt.busy_cnt = 22'(FLASH_WAIT_CYC);
                            end else if (b1 == `ISP_WR_EE) begin
                                ee_we          = 1'b1;
                                ee_addr        = b3[6:0];
                                ee_wd          = b4;
                                s_nxt.busy_cnt = 22'(EE_WAIT_CYC);
                            end else if (b1 == `ISP_LD_EE) begin
                                eb_we = 1'b1;
                                s_nxt.evalid[eb_idx] = 1'b1;
                            end else if (b1 == `ISP_WR_EE_PAGE) begin
                                s_nxt.op       = isp_pkg::OP_ECOPY;
                                s_nxt.page     = {4'h0, b3[5:2]};
                                s_nxt.ptr      = '0;
                                s_nxt.busy_cnt = 22'(EE_WAIT_CYC);
                            end
                        end
                    end
                end
            end
        end
    end

    // pin synchronisers reset to the idle levels of the link
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_r       <= '0;
            s_r.rst_m <= 1'b1;
            s_r.rst_s <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // arrays hold no reset; contents are unknown until erased or written
    always_ff @(posedge core_clk) begin
        if (fl_we) begin
            flash_mem[fl_addr] <= fl_wd;
        end
        if (ee_we) begin
            ee_mem[ee_addr] <= ee_wd;
        end
        if (fb_we_lo) begin
            fbuf[fb_idx][7:0] <= buf_wd;
        end
        if (fb_we_hi) begin
            fbuf[fb_idx][15:8] <= buf_wd;
        end
        if (eb_we) begin
            ebuf[eb_idx] <= buf_wd;
        end
    end
endmodule : isp_target

// *** testbench/isp_link_sva.sv ***
// link checker: assertions on the four programming wires
// assumes both ends share core_clk and reset
`timescale 1ns/1ps
module isp_link_sva #(
    parameter int unsigned PWRUP_CYC = 200
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic rst_pin_n
);
    int unsigned up_cnt_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles since reset, saturating so it never wraps
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) up_cnt_r <= 0;
        else if (up_cnt_r < PWRUP_CYC) up_cnt_r <= up_cnt_r + 1;
    end
    a_sck_low_phase: assert property ($fell(sck) |-> !sck [*7]) else $error("sck low short");
    a_sck_high_phase: assert property ($rose(sck) |-> sck [*7]) else $error("sck high short");
    a_mosi_held_high: assert property (sck && $past(sck) |-> $stable(mosi)) else $error("mosi moved");
    a_miso_moves_low: assert property ($changed(miso) |-> !sck) else $error("miso moved");
    a_miso_quiet_run: assert property (rst_pin_n [*6] |-> !miso) else $error("miso driven");
    a_sck_still_out: assert property (rst_pin_n |-> !sck) else $error("sck outside session");
    a_pulse_width: assert property ($rose(rst_pin_n) |-> rst_pin_n [*2]) else $error("pulse short");
    a_powerup_wait: assert property ($rose(sck) |-> up_cnt_r >= PWRUP_CYC) else $error("early");
    c_frame: cover property ($rose(sck));
    c_release: cover property ($rose(rst_pin_n));
    c_reply: cover property ($rose(miso));
endmodule : isp_link_sva

// *** testbench/testbench.sv ***
// bench: programmer and target joined, random flash and eeprom traffic
// assumes the shared header and package are compiled first
`timescale 1ns/1ps
module testbench;
    logic        core_clk = 0;
    logic        reset = 1;
    logic        session_en = 0;
    logic [31:0] cmd_data = 0;
    logic        cmd_valid = 0;
    logic [9:0]  fetch_addr = 0;
    logic        cmd_ready, rsp_valid, synced, prog_mode, write_in_progress_flag;
    logic [31:0] rsp_data, r;
    logic [15:0] fetch_data;
    integer      seed = 32'hB60F;
    integer      fail_count = 0;
    integer      checked = 0;
    logic [9:0]  fa;
    logic [7:0]  d [4];
    logic [6:0]  ea;
    isp_link_if isp_link_if_i ();
    isp_programmer #(.PWRUP_CYC(200)) isp_programmer_i (.core_clk(core_clk), .reset(reset),
        .link(isp_link_if_i.host), .session_en(session_en), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .synced(synced));
    isp_target #(.FLASH_WAIT_CYC(100), .EE_WAIT_CYC(100), .ERASE_WAIT_CYC(1100)) isp_target_i (
        .core_clk(core_clk), .reset(reset), .link(isp_link_if_i.device), .fetch_addr(fetch_addr),
        .fetch_data(fetch_data), .prog_mode(prog_mode), .write_in_progress_flag(write_in_progress_flag));
    isp_link_sva #(.PWRUP_CYC(200)) isp_link_sva_i (.core_clk(core_clk), .reset(reset), .sck(isp_link_if_i.sck),
        .mosi(isp_link_if_i.mosi), .miso(isp_link_if_i.miso), .rst_pin_n(isp_link_if_i.rst_pin_n));
    always #5 core_clk = ~core_clk;
    task automatic end_of_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // page-mode eeprom: offsets 0 and 2 loaded, 1 and 3 keep the erased value
    function automatic logic [7:0] ee_exp(input int i);
        return i[0] ? 8'hFF : d[i+1];
    endfunction : ee_exp
    // one word at a time; reply matched by its echoed first byte; only user words raise rsp_valid, polls do not
    task automatic cmd(input logic [31:0] w);
        int n;
        @(negedge core_clk);
        cmd_data = w;
        cmd_valid = 1;
        @(negedge core_clk);
        cmd_valid = 0;
        for (n = 0; n < 6000; n++) begin
            @(negedge core_clk);
            if (rsp_valid && rsp_data[23:16] === w[31:24]) break;
        end
        if (n == 6000) begin
            fail_count++;
            end_of_test();
        end
        r = rsp_data;
    endtask : cmd
    // erase, flash page, eeprom byte and page, poll, then release
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset = 0;
        session_en = 1;
        chk(cmd_ready, 1);
        fa = $random(seed);
        ea = {1'b1, 6'($random(seed))};
        for (int i = 0; i < 4; i++) d[i] = $random(seed);
        cmd(32'hAC80_0000);
        chk(synced, 1);
        for (int i = 0; i < 4; i++) cmd({4'h4, i[0], 11'h0, 2'h0, fa[5:1], i[1], d[i]});
        cmd({16'h4C00, 2'h0, fa[9:6], 10'h0});
        for (int i = 0; i < 4; i++) begin
            cmd({4'h2, i[0], 9'h0, fa[9:6], fa[5:1], i[1], 8'h0});
            chk(r[7:0], d[i]);
        end
        cmd({14'h0800, fa[9:6], ~fa[5], fa[4:1], 9'h0});
        chk(r[7:0], 8'hFF);
        cmd({16'hC000, 1'b0, ea, d[0]});
        chk(write_in_progress_flag, 1);
        cmd({16'hA000, 1'b0, ea, 8'h0});
        chk(r[7:0], d[0]);
        for (int i = 0; i < 4; i += 2) cmd({16'hC100, 6'h0, i[1:0], d[i+1]});
        cmd({16'hC200, 2'h0, ea[3:0], 10'h0});
        for (int i = 0; i < 4; i++) begin
            cmd({16'hA000, 2'h0, ea[3:0], i[1:0], 8'h0});
            chk(r[7:0], ee_exp(i));
        end
        cmd(32'hF000_0000);
        chk(r[0], 0);
        chk(prog_mode, 1);
        fetch_addr = {fa[9:1], 1'b0};
        session_en = 0;
        for (int n = 0; n < 50 && prog_mode !== 1'b0; n++) @(negedge core_clk);
        // linger so the released pin is watched for several clocks
        repeat (8) @(negedge core_clk);
        chk(prog_mode, 0);
        chk(fetch_data, {d[1], d[0]});
        end_of_test();
    end
endmodule : testbench
